// File: hdl/vtag_custom_cmds.sv
// Custom-command handler of a vicinity label with AXI4-Lite registers
`timescale 1ns/1ps
`include "vtag_cfg.svh"
module vtag_custom_cmds (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Decoded request bytes, CRC already checked and stripped
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_last_i,
    output logic rx_ready_o,
    // Response bytes; the framer appends the CRC
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_last_o,
    input wire logic tx_ready_i,
    // Identity and anticollision context
    input wire logic [63:0] uid_i,
    input wire logic selected_i,
    input wire logic select_evt_i,
    input wire logic reset_ready_evt_i,
    input wire logic off_expired_i,
    // Request filter for the protocol engine
    input wire logic [7:0] hdr_flags_i,
    input wire logic [7:0] hdr_cmd_i,
    input wire logic hdr_both_quiet_i,
    output logic req_process_o,
    output logic pquiet_o,
    // Configuration-memory view of the signature
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_blk_i,
    output logic [31:0] cfg_data_o,
    output logic cfg_ok_o
);

    ////////////////////////////////////////////////////////////////////
    vtag_pkg::st_t q, d;

    // Byte of the response at position idx
    function automatic logic [7:0] resp_byte(input vtag_pkg::st_t s,
                                             input logic [5:0] i);
        logic [5:0] k;
        logic [31:0] feat_w;
        k = i - 6'd1;
        feat_w = sys_feat(s.feat);
        resp_byte = 8'h00;
        unique case (s.kind)
            vtag_pkg::K_SYS: begin
                unique case (i)
                    6'd0: resp_byte = `RSP_FLAGS_OK;
                    6'd1: resp_byte = s.ctrl[7:0];
                    6'd2: resp_byte = s.ctrl[15:8] & `COND_MASK;
                    6'd3: resp_byte = s.ctrl[23:16] & `LOCK_MASK;
                    default: begin
                        // Bytes 4 to 7 carry the masked feature word; later bytes form
                        // an all-reserved second feature word
                        resp_byte = (i < 6'd8) ? feat_w[8*i[1:0] +: 8]
                                               : 8'h00;
                    end
                endcase
            end
            vtag_pkg::K_SIG: begin
                if (i == 6'd0) begin
                    resp_byte = `RSP_FLAGS_OK;
                end else begin
                    resp_byte = s.sig[k[5:2]][8*k[1:0] +: 8];
                end
            end
            default: begin
                resp_byte = (i == 6'd0) ? `RSP_FLAGS_ERR
                                        : `SIG_ERR_CODE;
            end
        endcase
    endfunction : resp_byte

    // Feature word with reserved bits forced low
    function automatic logic [31:0] sys_feat(input logic [31:0] f);
        sys_feat = f & `FEAT_MASK;
    endfunction : sys_feat

    // Register read value, flag for a mapped address
    function automatic logic [32:0] reg_read(input vtag_pkg::st_t s,
                                             input logic [11:0] a);
        logic [11:0] so;
        so = a - `OFS_SIG;
        reg_read = {1'b1, 32'h0000_0000};
        if (a == `OFS_CTRL) begin
            reg_read[31:0] = s.ctrl;
        end else if (a == `OFS_FEAT) begin
            reg_read[31:0] = s.feat;
        end else if (a == `OFS_STAT) begin
            reg_read[31:0] = {30'h0, s.fsm == vtag_pkg::ST_RESP, s.pquiet};
        end else if (a >= `OFS_SIG && so[11:2] < 10'(`SIG_WORDS)
                     && a[1:0] == 2'h0) begin
            reg_read[31:0] = s.sig[so[5:2]];
        end else begin
            reg_read[32] = 1'b0;
        end
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////
    // Persistent-quiet request filter for the protocol engine
    always_comb begin
        if (!q.pquiet) begin
            req_process_o = 1'b1;
        end else if (hdr_cmd_i == `CMD_EAS_ALARM) begin
            req_process_o = 1'b1;
        end else if (hdr_flags_i[`F_INVENTORY]) begin
            req_process_o = hdr_flags_i[`F_AFI] | hdr_both_quiet_i;
        end else begin
            req_process_o = hdr_flags_i[`F_ADDRESS]
                          | hdr_flags_i[`F_SELECT];
        end
    end

    // Stream handshakes are combinational from state
    assign rx_ready_o = q.fsm == vtag_pkg::ST_RX;
    assign tx_valid_o = q.fsm == vtag_pkg::ST_RESP;
    assign tx_last_o = tx_valid_o && (q.idx == q.len - 6'd1);
    assign tx_data_o = q.tx_byte;
    assign pquiet_o = q.pquiet;
    assign cfg_data_o = q.cfg_data;
    assign cfg_ok_o = q.cfg_ok;
    assign s_axi_awready_o = !q.aw_have && !q.bvalid;
    assign s_axi_wready_o = !q.w_have && !q.bvalid;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = !q.rvalid;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;

    ////////////////////////////////////////////////////////////////////
    // Next state: request parser, responder, quiet flag, registers
    always_comb begin
        logic [4:0] n;
        logic [5:0] ui;
        logic [4:0] hdr_len;
        logic [32:0] rr;
        logic [11:0] so;
        logic [3:0] last_blk;
        logic [32:0] rw;
        d = q;
        n = q.rx_cnt + 5'd1;
        ui = 6'(q.rx_cnt - 5'd3);
        hdr_len = 5'd0;
        rr = 33'h0;
        so = q.aw_addr - `OFS_SIG;
        last_blk = q.ctrl[`CTRL_SIG48] ? 4'd11 : 4'd7;
        rw = reg_read(q, q.aw_addr);
        unique case (q.fsm)
            vtag_pkg::ST_RX: begin
                if (rx_valid_i) begin
                    // Fields: flags, command, maker, optional UID
                    unique case (q.rx_cnt)
                        5'd0: begin
                            d.flags = rx_data_i;
                            d.hdr_ok = 1'b1;
                        end
                        5'd1: d.cmd = rx_data_i;
                        5'd2: begin
                            if (rx_data_i != `MFG_CODE) begin
                                d.hdr_ok = 1'b0;
                            end
                        end
                        default: begin
                            if (q.rx_cnt > 5'd10
                                || rx_data_i != uid_i[8*ui +: 8]) begin
                                d.hdr_ok = 1'b0;
                            end
                        end
                    endcase
                    d.rx_cnt = n;
                    if (rx_last_i) begin
                        d.rx_cnt = 5'd0;
                        hdr_len = q.flags[`F_ADDRESS] ? `HDR_UID
                                                      : `HDR_PLAIN;
                        if (q.rx_cnt == 5'd0) begin
                            hdr_len = 5'd0;
                        end
                        if (d.hdr_ok && n == hdr_len
                            && (!q.flags[`F_SELECT] || selected_i)) begin
                            d.idx = 6'd0;
                            if (q.cmd == `CMD_SYSINFO) begin
                                d.kind = vtag_pkg::K_SYS;
                                d.len = q.feat[31] ? `LEN_SYSINFO_EXT
                                      : `LEN_SYSINFO;
                                d.fsm = vtag_pkg::ST_RESP;
                            end else if (q.cmd == `CMD_SIGREAD) begin
                                d.kind = q.ctrl[`CTRL_SIGBAD]
                                       ? vtag_pkg::K_ERR
                                       : vtag_pkg::K_SIG;
                                d.len = q.ctrl[`CTRL_SIGBAD] ? `LEN_ERR
                                      : q.ctrl[`CTRL_SIG48] ? `LEN_SIG48
                                      : `LEN_SIG32;
                                d.fsm = vtag_pkg::ST_RESP;
                            end
                            d.tx_byte = resp_byte(d, 6'd0);
                        end
                    end
                end
            end
            vtag_pkg::ST_RESP: begin
                if (tx_ready_i) begin
                    d.idx = q.idx + 6'd1;
                    d.tx_byte = resp_byte(q, d.idx);
                    if (tx_last_o) begin
                        d.fsm = vtag_pkg::ST_RX;
                    end
                end
            end
            default: d.fsm = vtag_pkg::ST_RX;
        endcase

        // Quiet exits; field loss alone never clears it
        if (select_evt_i || reset_ready_evt_i || off_expired_i) begin
            d.pquiet = 1'b0;
        end
        // Entry wins over a same-cycle exit; addressed only, no reply
        if (q.fsm == vtag_pkg::ST_RX && rx_valid_i && rx_last_i
            && d.hdr_ok && q.cmd == `CMD_PQUIET && n == `HDR_UID
            && q.flags[`F_ADDRESS] && !q.flags[`F_SELECT]) begin
            d.pquiet = 1'b1;
        end

        // Signature as configuration blocks
        if (cfg_rd_i) begin
            d.cfg_ok = cfg_blk_i <= {4'h0, last_blk};
            d.cfg_data = (cfg_blk_i < 8'(`SIG_WORDS))
                       ? q.sig[cfg_blk_i[3:0]] : 32'h0000_0000;
        end

        // AXI write: address and data in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata_i;
            d.w_strb = s_axi_wstrb_i;
        end
        if (q.aw_have && q.w_have) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = 2'b00;
            for (int b = 0; b < 4; b++) begin
                if (q.w_strb[b]) begin
                    if (q.aw_addr == `OFS_CTRL) begin
                        d.ctrl[8*b +: 8] = q.w_data[8*b +: 8];
                    end else if (q.aw_addr == `OFS_FEAT) begin
                        d.feat[8*b +: 8] = q.w_data[8*b +: 8];
                    end else if (rw[32] && q.aw_addr >= `OFS_SIG) begin
                        d.sig[so[5:2]][8*b +: 8] = q.w_data[8*b +: 8];
                    end
                end
            end
            if (!rw[32] || q.aw_addr == `OFS_STAT) begin
                d.bresp = 2'b10; // Unmapped or read-only
            end
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
        end

        // AXI read answers one cycle after the address is taken
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rr = reg_read(q, s_axi_araddr_i);
            d.rvalid = 1'b1;
            d.rdata = rr[31:0];
            d.rresp = rr[32] ? 2'b00 : 2'b10;
        end else if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
    end

    // Single state register; pquiet resets only on power-on
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.ctrl <= `CTRL_RST;
            q.feat <= `FEAT_RST;
        end else begin
            q <= d;
        end
    end

endmodule : vtag_custom_cmds

// File: hdl/vtag_cfg.svh
// Offsets, field positions, codes and reset values of the tag block
`ifndef VTAG_CFG_SVH
`define VTAG_CFG_SVH
`define CMD_SYSINFO 8'hab
`define CMD_PQUIET 8'hbc
`define CMD_SIGREAD 8'hbd
`define CMD_EAS_ALARM 8'ha5
`define MFG_CODE 8'h5a
`define SIG_ERR_CODE 8'h0f
`define RSP_FLAGS_OK 8'h00
`define RSP_FLAGS_ERR 8'h01
`define F_INVENTORY 2
`define F_SELECT 4
`define F_AFI 4
`define F_ADDRESS 5
`define COND_MASK 8'h33
`define LOCK_MASK 8'h0f
`define FEAT_MASK 32'h8000_ffff
`define OFS_CTRL 12'h000
`define OFS_FEAT 12'h004
`define OFS_STAT 12'h008
`define OFS_SIG 12'h040
`define SIG_WORDS 12
`define CTRL_SIG48 24
`define CTRL_SIGBAD 25
`define CTRL_RST 32'h0000_0000
`define FEAT_RST 32'h0000_7fff
`define LEN_SYSINFO 6'd8
`define LEN_SYSINFO_EXT 6'd12
`define LEN_SIG32 6'd33
`define LEN_SIG48 6'd49
`define LEN_ERR 6'd2
`define HDR_PLAIN 5'd3
`define HDR_UID 5'd11
`endif

// File: hdl/vtag_pkg.sv
// Types shared by the tag custom-command block
package vtag_pkg;
    typedef enum logic [1:0] {ST_RX, ST_RESP} fsm_t;
    typedef enum logic [1:0] {K_SYS, K_SIG, K_ERR} kind_t;
    typedef struct packed {
        fsm_t fsm;
        kind_t kind;
        logic [4:0] rx_cnt;
        logic [7:0] flags;
        logic [7:0] cmd;
        logic hdr_ok;
        logic [5:0] idx;
        logic [5:0] len;
        logic [7:0] tx_byte;
        logic pquiet;
        logic [31:0] ctrl;
        logic [31:0] feat;
        logic [11:0][31:0] sig;
        logic [31:0] cfg_data;
        logic cfg_ok;
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } st_t;
endpackage : vtag_pkg

// File: sim/vtag_custom_cmds_props.sv
// Port-level assertions for the tag custom-command block
`timescale 1ns/1ps
`include "vtag_cfg.svh"
module vtag_props (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    input wire logic rx_ready_o,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_last_o,
    input wire logic tx_ready_i,
    input wire logic select_evt_i,
    input wire logic reset_ready_evt_i,
    input wire logic off_expired_i,
    input wire logic [7:0] hdr_flags_i,
    input wire logic [7:0] hdr_cmd_i,
    input wire logic hdr_both_quiet_i,
    input wire logic req_process_o,
    input wire logic pquiet_o,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_blk_i,
    input wire logic cfg_ok_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // Any exit pulse; a quiet entry in the same cycle wins over it
    logic exit_ev;
    assign exit_ev = select_evt_i | reset_ready_evt_i | off_expired_i;
    sequence s_rx_end; rx_valid_i && rx_ready_o && rx_last_i; endsequence
    sequence s_reply; s_rx_end ##1 tx_valid_o; endsequence
    ////////////////////////////////////////////////////////////////////
    chk_first_flags: assert property (s_reply |->
        tx_data_o inside {8'h00, 8'h01}) else $error("bad flags byte");
    chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o)) else $error("tx byte moved");
    chk_tx_done: assert property (tx_valid_o && tx_ready_i && tx_last_o
        |=> !tx_valid_o && rx_ready_o) else $error("reply overran");
    chk_quiet_silent: assert property ($rose(pquiet_o) |->
        (!tx_valid_o) [*4]) else $error("reply to quiet command");
    chk_inv_drop: assert property (pquiet_o && hdr_flags_i[2] &&
        !hdr_flags_i[4] && !hdr_both_quiet_i && hdr_cmd_i != 8'ha5
        |-> !req_process_o) else $error("inventory not dropped");
    chk_quiet_serve: assert property (pquiet_o && (hdr_cmd_i == 8'ha5 ||
        !hdr_flags_i[2] && (hdr_flags_i[5] || hdr_flags_i[4]))
        |-> req_process_o) else $error("request dropped");
    chk_quiet_exit: assert property (pquiet_o && exit_ev &&
        !rx_valid_i |=> !pquiet_o) else $error("quiet not left");
    chk_quiet_stays: assert property (pquiet_o && !exit_ev
        |=> pquiet_o) else $error("quiet lost");
    chk_cfg_range: assert property (cfg_rd_i && cfg_blk_i > 8'd11
        |=> !cfg_ok_o) else $error("block out of range");
endmodule : vtag_props

// File: sim/vtag_reader_model.sv
// Interrogator model: sends request frames and collects reply bytes
`timescale 1ns/1ps
module vtag_reader_model (
    input wire logic mclk_i,
    input wire logic slow_i,
    input wire logic rx_ready_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_last_o,
    output logic tx_ready_o
);
    logic [7:0] rsp_q[$];
    initial begin
        rx_valid_o = 0;
        rx_data_o = 8'h00;
        rx_last_o = 0;
        tx_ready_o = 1;
    end
    // Take reply bytes; a slow reader stalls two cycles in three
    always @(posedge mclk_i) begin
        if (tx_valid_i && tx_ready_o) rsp_q.push_back(tx_data_i);
        tx_ready_o <= !slow_i || ($urandom % 3 == 0);
    end
    // Frame: flags, command, maker code, UID only when addressed
    task automatic req(input logic [7:0] fl, cmd, mfg,
                       input logic [63:0] uid);
        logic [7:0] b[$];
        b = '{fl, cmd, mfg};
        if (fl[5]) for (int k = 0; k < 8; k++) b.push_back(uid[8*k +: 8]);
        foreach (b[k]) begin
            rx_valid_o <= 1;
            rx_data_o <= b[k];
            rx_last_o <= k == b.size() - 1;
            @(posedge mclk_i iff rx_ready_i);
        end
        // Released line shows no stale byte
        rx_valid_o <= 0;
        rx_last_o <= 0;
        rx_data_o <= ~b[b.size() - 1];
    endtask : req
endmodule : vtag_reader_model

// File: sim/tb_vtag_custom_cmds.sv
// Self-checking bench for the tag custom-command block
`timescale 1ns/1ps
`include "vtag_cfg.svh"
module tb_vtag_custom_cmds;
    logic mclk_i = 0, arst_n_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
    logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic [11:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, cfg_data_o, ctrl, feat, v;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, rx_valid_i, rx_last_i, rx_ready_o, tx_valid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
    logic tx_last_o, tx_ready_i, req_process_o, pquiet_o, cfg_ok_o, slow = 0;
    logic [7:0] rx_data_i, tx_data_o, hdr_flags_i = 0, hdr_cmd_i = 0;
    logic [7:0] cfg_blk_i = 0, e[$];
    logic [63:0] uid_i = 64'h0123_4567_89ab_cdef;
    logic selected_i = 0, select_evt_i = 0, reset_ready_evt_i = 0;
    logic off_expired_i = 0, hdr_both_quiet_i = 0, cfg_rd_i = 0;
    logic [31:0] sig[12];
    int n_fail = 0, num_checks = 0;
    always #2 mclk_i = ~mclk_i;
    vtag_custom_cmds i_dut (.*);
    vtag_reader_model i_rdr (.mclk_i(mclk_i), .slow_i(slow),
        .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i),
        .rx_data_o(rx_data_i), .rx_last_o(rx_last_i), .tx_ready_o(tx_ready_i));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // Write with address and data offered together, each freed when taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        do begin
            @(posedge mclk_i);
            ta |= s_axi_awready_o;
            tw |= s_axi_wready_o;
            if (ta) s_axi_awvalid_i <= 0;
            if (tw) s_axi_wvalid_i <= 0;
        end while (!(ta && tw));
        do @(posedge mclk_i); while (!s_axi_bvalid_o);
        s_axi_bready_i <= 0;
        r = s_axi_bresp_o;
        // One idle edge so the next call never reassigns in this step
        @(posedge mclk_i);
    endtask : axw
    task automatic axr(input logic [11:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        do @(posedge mclk_i); while (!s_axi_arready_o);
        s_axi_arvalid_i <= 0;
        do @(posedge mclk_i); while (!s_axi_rvalid_o);
        s_axi_rready_i <= 0;
        v = s_axi_rdata_o;
        r = s_axi_rresp_o;
        @(posedge mclk_i);
    endtask : axr
    // Send one request and wait until any reply has drained
    task automatic run(input logic [7:0] fl, cmd, mfg);
        i_rdr.rsp_q.delete();
        i_rdr.req(fl, cmd, mfg, uid_i);
        repeat (2) @(posedge mclk_i);
        while (!rx_ready_o) @(posedge mclk_i);
        check(i_rdr.rsp_q.size(), e.size());
        foreach (e[k]) check(i_rdr.rsp_q[k], e[k]);
    endtask : run
    function automatic logic want(input logic q, input logic [7:0] f, c,
                                  input logic b);
        if (!q || c == 8'ha5) return 1;
        return f[2] ? (f[4] | b) : (f[5] | f[4]);
    endfunction : want
    // Random request headers against the quiet-state filter
    task automatic filt;
        for (int k = 0; k < 24; k++) begin
            hdr_flags_i <= 8'($urandom);
            hdr_cmd_i <= k[0] ? 8'ha5 : 8'($urandom);
            hdr_both_quiet_i <= 1'($urandom);
            @(posedge mclk_i);
            check(req_process_o, want(pquiet_o, hdr_flags_i, hdr_cmd_i,
                  hdr_both_quiet_i));
        end
    endtask : filt
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h566f));
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1;
        @(posedge mclk_i);
        axr(`OFS_FEAT);
        check(v, 32'h0000_7fff);
        check(r, 2'b00);
        axw(`OFS_STAT, 32'hffff_ffff);
        check(r, 2'b10);
        axr(12'h0fc);
        check(r, 2'b10);
        filt();
        // System information: all ones, all zeros, then random settings
        for (int i = 0; i < 4; i++) begin
            ctrl = $urandom & 32'h00ff_ffff;
            feat = i == 0 ? 32'hffff_ffff : i == 1 ? 32'h0 : $urandom;
            slow <= i[0];
            axw(`OFS_CTRL, ctrl);
            axw(`OFS_FEAT, feat);
            feat &= 32'h8000_ffff;
            e = '{8'h00, ctrl[7:0], ctrl[15:8] & 8'h33, ctrl[23:16] & 8'h0f,
                  feat[7:0], feat[15:8], feat[23:16], feat[31:24]};
            // A set top bit announces a second, all-reserved feature word
            if (feat[31]) repeat (4) e.push_back(8'h00);
            run(i[1] ? 8'h20 : 8'h00, 8'hab, `MFG_CODE);
        end
        foreach (sig[k]) begin
            sig[k] = $urandom;
            axw(`OFS_SIG + 12'(4 * k), sig[k]);
        end
        // Signature in both lengths, reply and block view
        for (int m = 0; m < 2; m++) begin
            axw(`OFS_CTRL, 32'(m) << 24);
            e = '{8'h00};
            for (int k = 0; k < 32 + 16 * m; k++)
                e.push_back(sig[k / 4][8 * (k % 4) +: 8]);
            run(8'h00, 8'hbd, `MFG_CODE);
            for (int b = 0; b < 13; b++) begin
                cfg_blk_i <= 8'(b);
                cfg_rd_i <= 1;
                @(posedge mclk_i);
                cfg_rd_i <= 0;
                @(posedge mclk_i);
                check(cfg_ok_o, b < 8 + 4 * m);
                if (b < 8 + 4 * m) check(cfg_data_o, sig[b]);
            end
        end
        axw(`OFS_CTRL, 32'h0200_0000);
        e = '{8'h01, `SIG_ERR_CODE};
        run(8'h00, 8'hbd, `MFG_CODE);
        e.delete();
        run(8'h00, 8'hab, ~`MFG_CODE);
        // Quiet entry, filtering and each of the three exits
        for (int m = 0; m < 3; m++) begin
            run(8'h30, 8'hbc, `MFG_CODE);
            check(pquiet_o, 0);
            run(8'h20, 8'hbc, `MFG_CODE);
            filt();
            check(pquiet_o, 1);
            axr(`OFS_STAT);
            check(v, 32'h0000_0001);
            select_evt_i <= m == 0;
            reset_ready_evt_i <= m == 1;
            off_expired_i <= m == 2;
            @(posedge mclk_i);
            {select_evt_i, reset_ready_evt_i, off_expired_i} <= 3'b000;
            @(posedge mclk_i);
            check(pquiet_o, 0);
        end
        results();
    end
    // A hang ends the run as a mismatch
    initial begin
        #200000;
        n_fail++;
        $display("[FAIL] %0t run did not finish", $time);
        results();
    end
endmodule : tb_vtag_custom_cmds
bind vtag_custom_cmds vtag_props i_props (.*);
